//--- hdl/dcsp_top.sv
// Purpose: display channel serial port with AXI4-Lite register access
// Assumes: pins are open-drain with external pull-ups
// Notes:   pin levels reach the status bits about two link plus two aclk cycles late

`timescale 1ns/1ps

module dcsp_top
#(
    parameter int unsigned ADDR_WIDTH = dcsp_pkg::ADDR_W  // register address width
)
(
    input  wire logic                  aclk,           // bus clock
    input  wire logic                  aresetn,        // synchronous reset, active low
    input  wire logic                  link_clk,       // pin-side clock
    input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,   // write address
    input  wire logic [2:0]            s_axi_awprot,   // write protection, unused
    input  wire logic                  s_axi_awvalid,  // write address valid
    output logic                       s_axi_awready,  // write address ready
    input  wire logic [31:0]           s_axi_wdata,    // write data
    input  wire logic [3:0]            s_axi_wstrb,    // write byte strobes
    input  wire logic                  s_axi_wvalid,   // write data valid
    output logic                       s_axi_wready,   // write data ready
    output logic [1:0]                 s_axi_bresp,    // write response
    output logic                       s_axi_bvalid,   // write response valid
    input  wire logic                  s_axi_bready,   // write response ready
    input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,   // read address
    input  wire logic [2:0]            s_axi_arprot,   // read protection, unused
    input  wire logic                  s_axi_arvalid,  // read address valid
    output logic                       s_axi_arready,  // read address ready
    output logic [31:0]                s_axi_rdata,    // read data
    output logic [1:0]                 s_axi_rresp,    // read response
    output logic                       s_axi_rvalid,   // read data valid
    input  wire logic                  s_axi_rready,   // read data ready
    input  wire logic                  scl_i,          // channel clock pin level
    output logic                       scl_o,          // channel clock pin drive value
    output logic                       scl_oe,         // channel clock pin drive enable
    input  wire logic                  sda_i,          // channel data pin level
    output logic                       sda_o,          // channel data pin drive value
    output logic                       sda_oe,         // channel data pin drive enable
    output logic                       monitor_route   // 1 connects pins to monitor lines
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        DCSP_SEL_NONE    = 2'b00,
        DCSP_SEL_PIN     = 2'b01,
        DCSP_SEL_ROUTE   = 2'b10
    } dcsp_sel_t;

    function automatic dcsp_sel_t dcsp_decode(input logic [ADDR_WIDTH-1:0] addr);
        logic [ADDR_WIDTH-1:0] word;
        word = {addr[ADDR_WIDTH-1:2], 2'b00};
        if (word == ADDR_WIDTH'(dcsp_pkg::PIN_CONTROL_OFFSET))
            dcsp_decode = DCSP_SEL_PIN;
        else if (word == ADDR_WIDTH'(dcsp_pkg::ROUTING_EXT_OFFSET))
            dcsp_decode = DCSP_SEL_ROUTE;
        else
            dcsp_decode = DCSP_SEL_NONE;
    endfunction : dcsp_decode

    function automatic logic [1:0] dcsp_resp(input dcsp_sel_t sel);
        dcsp_resp = (sel == DCSP_SEL_NONE) ? dcsp_pkg::RESP_SLVERR : dcsp_pkg::RESP_OKAY;
    endfunction : dcsp_resp

    // ------------------------------------------------------------
    // link side
    // ------------------------------------------------------------
    dcsp_link_if u_link ();

    dcsp_pin_port u_pin_port
    (
        .link_clk (link_clk),
        .aresetn  (aresetn),
        .lnk      (u_link.port),
        .scl_i    (scl_i),
        .scl_o    (scl_o),
        .scl_oe   (scl_oe),
        .sda_i    (sda_i),
        .sda_o    (sda_o),
        .sda_oe   (sda_oe)
    );

    // ------------------------------------------------------------
    // status crossing into aclk domain
    // ------------------------------------------------------------
    logic clk_seen_s1_q;
    logic clk_seen_s2_q;
    logic dat_seen_s1_q;
    logic dat_seen_s2_q;

    always_ff @(posedge aclk)
    begin
        clk_seen_s1_q <= u_link.clock_seen;
        clk_seen_s2_q <= clk_seen_s1_q;
    end

    always_ff @(posedge aclk)
    begin
        dat_seen_s1_q <= u_link.data_seen;
        dat_seen_s2_q <= dat_seen_s1_q;
    end

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    logic                  aw_held_q;
    logic [ADDR_WIDTH-1:0] aw_addr_q;
    logic                  w_held_q;
    logic [31:0]           w_data_q;
    logic [3:0]            w_strb_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;

    logic                  aw_take;
    logic                  w_take;
    logic                  aw_have;
    logic                  w_have;
    logic [ADDR_WIDTH-1:0] wr_addr;
    logic [31:0]           wr_data;
    logic [3:0]            wr_strb;
    logic                  wr_do;
    dcsp_sel_t             wr_sel;

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready  = ~w_held_q & ~bvalid_q;
    assign aw_take       = s_axi_awvalid & s_axi_awready;
    assign w_take        = s_axi_wvalid & s_axi_wready;
    assign aw_have       = aw_held_q | aw_take;
    assign w_have        = w_held_q | w_take;
    assign wr_do         = aw_have & w_have & ~bvalid_q;
    assign wr_addr       = aw_held_q ? aw_addr_q : s_axi_awaddr;
    assign wr_data       = w_held_q ? w_data_q : s_axi_wdata;
    assign wr_strb       = w_held_q ? w_strb_q : s_axi_wstrb;
    assign wr_sel        = dcsp_decode(wr_addr);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end
        else if (wr_do)
            aw_held_q <= 1'b0;
        else if (aw_take)
        begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
    end

    // ------------------------------------------------------------
    // write data
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            w_held_q <= 1'b0;
        else if (wr_do)
            w_held_q <= 1'b0;
        else if (w_take)
            w_held_q <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_data_q <= '0;
            w_strb_q <= '0;
        end
        else if (w_take && !wr_do)
        begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
    end

    // ------------------------------------------------------------
    // write response
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bvalid_q <= 1'b0;
        else if (wr_do)
            bvalid_q <= 1'b1;
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bresp_q <= dcsp_pkg::RESP_OKAY;
        else if (wr_do)
            bresp_q <= dcsp_resp(wr_sel);
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic clock_out_q;
    logic data_out_q;
    logic route_q;
    logic pin_we;
    logic route_we;

    assign pin_we   = wr_do & (wr_sel == DCSP_SEL_PIN) & wr_strb[0];
    assign route_we = wr_do & (wr_sel == DCSP_SEL_ROUTE) & wr_strb[0];

    // software bit-bangs the pins directly; no sequencing added here
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clock_out_q <= dcsp_pkg::CLOCK_OUT_RESET;
            data_out_q  <= dcsp_pkg::DATA_OUT_RESET;
        end
        else if (pin_we)
        begin
            clock_out_q <= wr_data[dcsp_pkg::CLOCK_OUT_BIT];
            data_out_q  <= wr_data[dcsp_pkg::DATA_OUT_BIT];
        end
    end

    // ------------------------------------------------------------
    // routing register
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            route_q <= dcsp_pkg::ROUTE_RESET;
        else if (route_we)
            route_q <= wr_data[dcsp_pkg::ROUTE_BIT];
    end

    assign monitor_route        = ~route_q;
    assign u_link.clock_release = clock_out_q;
    assign u_link.data_release  = data_out_q;

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] rd_word;
    dcsp_sel_t   rd_sel;

    assign s_axi_arready = ~rvalid_q;
    assign rd_sel        = dcsp_decode(s_axi_araddr);

    always_comb
    begin
        rd_word = '0;
        unique case (rd_sel)
            DCSP_SEL_PIN:
            begin
                rd_word[dcsp_pkg::DATA_STATUS_BIT]  = dat_seen_s2_q;
                rd_word[dcsp_pkg::CLOCK_STATUS_BIT] = clk_seen_s2_q;
                rd_word[dcsp_pkg::DATA_OUT_BIT]     = data_out_q;
                rd_word[dcsp_pkg::CLOCK_OUT_BIT]    = clock_out_q;
            end
            DCSP_SEL_ROUTE:
                rd_word[dcsp_pkg::ROUTE_BIT] = route_q;
            DCSP_SEL_NONE:
                rd_word = '0;
            default:
                rd_word = '0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rvalid_q <= 1'b0;
        else if (s_axi_arvalid && s_axi_arready)
            rvalid_q <= 1'b1;
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // read response
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata_q <= '0;
            rresp_q <= dcsp_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rdata_q <= rd_word;
            rresp_q <= dcsp_resp(rd_sel);
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule : dcsp_top

//--- hdl/dcsp_pkg.sv
// Purpose: constants for the display channel serial port
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   two registers, one aligned word each; upper bits read as zero
//
// Contract
// - exactly two channel signals, serial clock and serial data, two-wire protocol
// - routing bit 4 at zero connects clock and data pins to monitor connector
// - clock pin is two-way: drives clock out or accepts clock from far side
// - data pin is two-way: drives data out or receives data from far side
// - both pins open-drain: only pull low, external pull-up gives high
// - control register bit 7 shows data pin level, bit 2 clock pin level
// - control register bit 1 steers data pin, bit 0 steers clock pin
// - software relays decoder commands over same pins; port adds no protocol

package dcsp_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W                 = 12;
    localparam logic [11:0] PIN_CONTROL_OFFSET     = 12'h000;
    localparam logic [11:0] ROUTING_EXT_OFFSET     = 12'h004;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned DATA_STATUS_BIT        = 7;
    localparam int unsigned CLOCK_STATUS_BIT       = 2;
    localparam int unsigned DATA_OUT_BIT           = 1;
    localparam int unsigned CLOCK_OUT_BIT          = 0;
    localparam int unsigned ROUTE_BIT              = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic        DATA_OUT_RESET         = 1'b1;
    localparam logic        CLOCK_OUT_RESET        = 1'b1;
    localparam logic        ROUTE_RESET            = 1'b0;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY              = 2'h0;
    localparam logic [1:0]  RESP_SLVERR            = 2'h2;

    // ------------------------------------------------------------
    // synchroniser depth
    // ------------------------------------------------------------
    localparam int unsigned SYNC_STAGES            = 2;

endpackage : dcsp_pkg

//--- hdl/dcsp_link_if.sv
// Purpose: carries pin control and pin levels between core and pin port
// Assumes: release levels live on aclk, seen levels on the link clock
// Notes:   every signal is a level; receivers synchronise

`timescale 1ns/1ps

interface dcsp_link_if;
    logic clock_release;  // aclk domain: 1 releases the clock pin
    logic data_release;   // aclk domain: 1 releases the data pin
    logic clock_seen;     // link domain: sampled clock pin level
    logic data_seen;      // link domain: sampled data pin level

    modport core
    (
        output clock_release,
        output data_release,
        input  clock_seen,
        input  data_seen
    );

    modport port
    (
        input  clock_release,
        input  data_release,
        output clock_seen,
        output data_seen
    );
endinterface : dcsp_link_if

//--- hdl/dcsp_pin_port.sv
// Purpose: link-clock side of the channel, drives and samples the pins
// Assumes: link_clk runs while the channel is in use
// Notes:   open-drain: output value fixed low, only the enable moves

`timescale 1ns/1ps

module dcsp_pin_port
(
    input  wire logic  link_clk,    // link-side clock
    input  wire logic  aresetn,     // core reset, resynchronised here
    dcsp_link_if.port  lnk,         // core side signals
    input  wire logic  scl_i,       // channel clock pin level
    output logic       scl_o,       // channel clock pin drive value
    output logic       scl_oe,      // channel clock pin drive enable
    input  wire logic  sda_i,       // channel data pin level
    output logic       sda_o,       // channel data pin drive value
    output logic       sda_oe       // channel data pin drive enable
);

    // ------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;

    always_ff @(posedge link_clk)
    begin
        rst_s1_q <= aresetn;
        rst_s2_q <= rst_s1_q;
    end

    // ------------------------------------------------------------
    // control crossing into link domain
    // ------------------------------------------------------------
    logic clk_rel_s1_q;
    logic clk_rel_s2_q;
    logic dat_rel_s1_q;
    logic dat_rel_s2_q;

    always_ff @(posedge link_clk)
    begin
        clk_rel_s1_q <= lnk.clock_release;
        clk_rel_s2_q <= clk_rel_s1_q;
        dat_rel_s1_q <= lnk.data_release;
        dat_rel_s2_q <= dat_rel_s1_q;
    end

    // ------------------------------------------------------------
    // open-drain drivers
    // ------------------------------------------------------------
    logic scl_oe_q;
    logic sda_oe_q;

    always_ff @(posedge link_clk)
    begin
        if (!rst_s2_q)
        begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else
        begin
            scl_oe_q <= ~clk_rel_s2_q;
            sda_oe_q <= ~dat_rel_s2_q;
        end
    end

    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    logic scl_s1_q;
    logic scl_s2_q;
    logic sda_s1_q;
    logic sda_s2_q;

    always_ff @(posedge link_clk)
    begin
        scl_s1_q <= scl_i;
        scl_s2_q <= scl_s1_q;
        sda_s1_q <= sda_i;
        sda_s2_q <= sda_s1_q;
    end

    assign lnk.clock_seen = scl_s2_q;
    assign lnk.data_seen  = sda_s2_q;

endmodule : dcsp_pin_port

//--- bench/dcsp_chk.sv
// Purpose: bus handshake and pin drive checks at the top ports
// Assumes: every check lives in the aclk domain
// Notes:   attached to dcsp_top by the bind at the foot of this file

`timescale 1ns/1ps

module dcsp_chk
(
    input wire logic        aclk,           // bus clock
    input wire logic        aresetn,        // synchronous reset, active low
    input wire logic        s_axi_awvalid,  // write address valid
    input wire logic        s_axi_awready,  // write address ready
    input wire logic        s_axi_wvalid,   // write data valid
    input wire logic        s_axi_wready,   // write data ready
    input wire logic        s_axi_bvalid,   // write response valid
    input wire logic        s_axi_bready,   // write response ready
    input wire logic        s_axi_arvalid,  // read address valid
    input wire logic        s_axi_arready,  // read address ready
    input wire logic        s_axi_rvalid,   // read data valid
    input wire logic        s_axi_rready,   // read data ready
    input wire logic [31:0] s_axi_rdata,    // read data
    input wire logic        scl_o,          // clock pin drive value
    input wire logic        sda_o,          // data pin drive value
    input wire logic        monitor_route   // pins routed to monitor
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_drive_low: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("pin drive value not low");
    a_route_cause: assert property ($changed(monitor_route) |-> $rose(s_axi_bvalid))
        else $error("route changed without a write");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_bresp_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    a_rdata_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not released");
endmodule : dcsp_chk

bind dcsp_top dcsp_chk u_chk
(
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .scl_o, .sda_o, .monitor_route
);

//--- bench/dcsp_far_end.sv
// Purpose: far side of the channel: pull-ups, a peer that can hold lines low
// Assumes: both lines open-drain with pull-ups
// Notes:   receiver captures one byte, msb first, after a start condition

`timescale 1ns/1ps

module dcsp_far_end
(
    input wire logic  scl_o,         // device clock drive value
    input wire logic  scl_oe,        // device clock drive enable
    input wire logic  sda_o,         // device data drive value
    input wire logic  sda_oe,        // device data drive enable
    input wire logic  hold_scl_low,  // peer stretches the clock
    input wire logic  hold_sda_low,  // peer pulls data low
    output logic      scl_line,      // resolved clock line
    output logic      sda_line,      // resolved data line
    output logic [7:0] rx_byte       // byte seen by the peer
);
    logic [3:0] bit_cnt = 4'h8;

    assign scl_line = (scl_oe ? scl_o : 1'b1) & ~hold_scl_low;
    assign sda_line = (sda_oe ? sda_o : 1'b1) & ~hold_sda_low;

    // start condition arms the receiver
    always @(negedge sda_line)
        if (scl_line === 1'b1)
            bit_cnt = 4'h0;

    always @(posedge scl_line)
        if (bit_cnt < 4'h8)
        begin
            rx_byte = {rx_byte[6:0], sda_line};
            bit_cnt = bit_cnt + 4'h1;
        end
endmodule : dcsp_far_end

//--- bench/display_channel_serial_port_test.sv
// Purpose: register-level test of the display channel serial port
// Assumes: AXI4-Lite master tasks, far side from dcsp_far_end
// Notes:   waits 60 cycles after each write for the pins to settle

`timescale 1ns/1ps

module display_channel_serial_port_test;
    logic aclk = 1'b0, link_clk = 1'b0, aresetn = 1'b0, far_scl = 1'b0, far_sda = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, monitor_route;
    wire [7:0] rx_byte;
    int err_total = 0;
    int cmp_count = 0;
    localparam logic [11:0] CTL = dcsp_pkg::PIN_CONTROL_OFFSET;
    localparam logic [11:0] RTE = dcsp_pkg::ROUTING_EXT_OFFSET;
    localparam logic [1:0] OK = dcsp_pkg::RESP_OKAY;

    dcsp_top dut (.*);

    dcsp_far_end far
    (
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
        .hold_scl_low(far_scl), .hold_sda_low(far_sda),
        .scl_line(scl_i), .sda_line(sda_i), .rx_byte(rx_byte)
    );

    initial forever #2.5 aclk = ~aclk;

    initial
    begin
        #3.7;
        forever #16 link_clk = ~link_clk;
    end

    task automatic check_val(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : check_val

    task automatic check_pin(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask : check_pin

    // write, check the response, let the pins settle
    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        logic aw_hs, w_hs, b_hs;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid & s_axi_awready;
            w_hs = s_axi_wvalid & s_axi_wready;
            b_hs = s_axi_bvalid & s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
        end while (!b_hs);
        s_axi_bready <= 1'b0;
        check_val("bresp", {30'h0, er}, {30'h0, r});
        repeat (60) @(posedge aclk);
    endtask : wr_chk

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ar_hs, r_hs;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ar_hs = s_axi_arvalid & s_axi_arready;
            r_hs = s_axi_rvalid & s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
        end while (!r_hs);
        s_axi_rready <= 1'b0;
        check_val("rdata", e, d);
        check_val("rresp", {30'h0, er}, {30'h0, r});
    endtask : rd_chk

    function automatic logic [31:0] exp_ctl(input logic dl, input logic cl, input logic [1:0] v);
        return {24'h0, dl, 4'h0, cl, v};
    endfunction : exp_ctl

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    initial
    begin
        #60000;
        err_total++;
        final_report;
    end

    initial
    begin
        logic [1:0] v;
        logic [7:0] tx;
        logic dl;
        // held long enough for the link side to see it
        repeat (24) @(posedge aclk);
        aresetn <= 1'b1;
        // pin levels must pass both synchronisers before the first status read
        repeat (40) @(posedge aclk);
        rd_chk(CTL, 32'h0000_0087, OK);
        rd_chk(RTE, 32'h0, OK);
        check_pin("route", 1'b1, monitor_route);
        for (int i = 0; i < 4; i++)
        begin
            v = i[1:0];
            wr_chk(CTL, {30'h0, v}, 4'h1, OK);
            check_pin("scl_oe", ~v[0], scl_oe);
            check_pin("sda_oe", ~v[1], sda_oe);
            rd_chk(CTL, exp_ctl(v[1], v[0], v), OK);
        end
        far_sda <= 1'b1;
        repeat (60) @(posedge aclk);
        rd_chk(CTL, exp_ctl(1'b0, 1'b1, 2'h3), OK);
        far_scl <= 1'b1;
        repeat (60) @(posedge aclk);
        rd_chk(CTL, exp_ctl(1'b0, 1'b0, 2'h3), OK);
        far_scl <= 1'b0;
        far_sda <= 1'b0;
        wr_chk(RTE, 32'h0000_0010, 4'h1, OK);
        check_pin("route", 1'b0, monitor_route);
        rd_chk(RTE, 32'h0000_0010, OK);
        wr_chk(RTE, 32'h0, 4'h1, OK);
        check_pin("route", 1'b1, monitor_route);
        wr_chk(12'h008, 32'hFFFF_FFFF, 4'hF, dcsp_pkg::RESP_SLVERR);
        rd_chk(12'h008, 32'h0, dcsp_pkg::RESP_SLVERR);
        wr_chk(CTL, 32'h0, 4'h0, OK);
        rd_chk(CTL, 32'h0000_0087, OK);
        // start, then one byte clocked out msb first by software
        tx = 8'hA5;
        dl = 1'b0;
        wr_chk(CTL, 32'h1, 4'h1, OK);
        for (int i = 7; i >= 0; i--)
        begin
            wr_chk(CTL, {30'h0, dl, 1'b0}, 4'h1, OK);
            dl = tx[i];
            wr_chk(CTL, {30'h0, dl, 1'b0}, 4'h1, OK);
            wr_chk(CTL, {30'h0, dl, 1'b1}, 4'h1, OK);
        end
        check_val("rx_byte", {24'h0, tx}, {24'h0, rx_byte});
        final_report;
    end
endmodule : display_channel_serial_port_test
